// [core/wkt_defs.vh]
// constants for the wake-up timer block: offsets, fields, resets, counts
`ifndef WKT_DEFS_VH
`define WKT_DEFS_VH

`define WKT_ADDR_W          12
`define WKT_OFF_CONFIG      12'h000
`define WKT_OFF_MANT_HI     12'h004
`define WKT_OFF_MANT_LO     12'h008
`define WKT_OFF_EXP_STATE   12'h00C
`define WKT_OFF_DUTY_DUR    12'h010
`define WKT_OFF_CONTROL     12'h014
`define WKT_OFF_STATUS      12'h018
`define WKT_OFF_IRQ_STATUS  12'h01C
`define WKT_OFF_RC_TRIM     12'h020

// wake_timer_config fields
`define WKT_CFG_EN          0
`define WKT_CFG_BATT        1
`define WKT_CFG_MODE_LO     2
`define WKT_CFG_MODE_HI     3
`define WKT_CFG_CAL_EN      4
`define WKT_CFG_CALIV_LO    5
`define WKT_CFG_CALIV_HI    7

// wake_exponent_and_state fields
`define WKT_EXP_LO          0
`define WKT_EXP_HI          4
`define WKT_EXP_SLEEP_SEL   6

// control fields
`define WKT_CTL_CLK_SEL     0
`define WKT_CTL_WAKE_IE     1
`define WKT_CTL_TXDONE_IE   2
`define WKT_CTL_SLEEP_CMD   3
`define WKT_CTL_PWRUP_CMD   4
`define WKT_CTL_SHDN_CMD    5

// interrupt status bits
`define WKT_IRQ_WAKE        0
`define WKT_IRQ_TXDONE      1

// duty-cycle mode codes
`define WKT_MODE_OFF        2'h0
`define WKT_MODE_RX         2'h1
`define WKT_MODE_TX         2'h2

// reset values
`define WKT_RST_CONFIG      8'h00
`define WKT_RST_MANT_HI     8'h00
`define WKT_RST_MANT_LO     8'h00
`define WKT_RST_EXP_STATE   8'h00
`define WKT_RST_DUTY_DUR    8'h00
`define WKT_RST_CONTROL     8'h00
`define WKT_RST_RC_TRIM     7'h40

// timing: pclk frequency and calibration window
`define WKT_PCLK_HZ         10000000
`define WKT_SLOW_HZ         32768
`define WKT_UNIT_TICKS_LOG2 2
`define WKT_CAL_TICKS       16
`define WKT_CAL_EXPECT      ((`WKT_CAL_TICKS * `WKT_PCLK_HZ) / `WKT_SLOW_HZ)
`define WKT_CALIV_BASE      32768

`endif

// [core/wkt_top.v]
// wake-up timer with rc calibration and low duty cycle rx/tx polling
//
// Notes on behaviour
// - counter clocked by selectable 32 kHz source
// - enabled timer counts exponent/mantissa period
// - expiry drives irq low when masked in
// - period is mantissa times four times two^exponent
// - mantissa is sixteen bits, high and low byte
// - exponent five bits, shares register with state select
// - after wake go ready (0) or sleep (1)
// - calibrate rc on power-up and shutdown exit
// - periodic recalibration when enabled, 3-bit interval
// - calibration starts crystal, compares, trims rc
// - mode 0 off, 1 rx start, 2 tx start
// - duty duration same formula with duty parameter
// - rx: no preamble/error/incomplete returns to idle
// - rx: preamble detect extends active window
// - after two windows give up until next wake
// - tx: send on wake, irq when enabled
// - after tx return idle until next wake
// - battery check on each wake when enabled
`timescale 1ns/1ps
`include "wkt_defs.vh"

module wkt_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_ff,
  output reg         pready_ff,
  output reg         pslverr_ff,
  input  wire        rc_clk_32k,
  input  wire        xtal_clk_32k,
  input  wire        preamble_detect,
  input  wire        rx_error,
  input  wire        packet_received,
  input  wire        tx_done,
  input  wire        xo_ready,
  output reg         interrupt_request_n_ff,
  output reg         rx_enable_ff,
  output reg         tx_start_ff,
  output reg         battery_measure_ff,
  output reg         xo_enable_ff,
  output reg  [6:0]  rc_trim_ff,
  output reg  [5:0]  chip_state_ff
);

  localparam [5:0] ST_OFF   = 6'h01;
  localparam [5:0] ST_READY = 6'h02;
  localparam [5:0] ST_SLEEP = 6'h04;
  localparam [5:0] ST_CAL   = 6'h08;
  localparam [5:0] ST_RX    = 6'h10;
  localparam [5:0] ST_TX    = 6'h20;

  localparam integer CAL_EXPECT_I = `WKT_CAL_EXPECT;
  localparam integer CAL_TICKS_I  = `WKT_CAL_TICKS;
  localparam integer CALIV_BASE_I = `WKT_CALIV_BASE;
  localparam [12:0]  CAL_EXPECT   = CAL_EXPECT_I[12:0];
  localparam [4:0]   CAL_TICKS    = CAL_TICKS_I[4:0];
  localparam [22:0]  CALIV_BASE   = CALIV_BASE_I[22:0];

  // ticks of the slow clock per formula unit: 4 * 2^exp
  function [33:0] unit_len;
    input [4:0] exp_v;
    begin
      unit_len = 34'h1 << (exp_v + `WKT_UNIT_TICKS_LOG2);
    end
  endfunction

  function [7:0] rd_byte_lane;
    input [11:0] a;
    input [7:0]  cfg;
    input [7:0]  mhi;
    input [7:0]  mlo;
    input [7:0]  exs;
    input [7:0]  dur;
    input [7:0]  ctl;
    input [7:0]  sts;
    input [7:0]  irq;
    input [7:0]  trm;
    begin
      case (a)
        `WKT_OFF_CONFIG:     rd_byte_lane = cfg;
        `WKT_OFF_MANT_HI:    rd_byte_lane = mhi;
        `WKT_OFF_MANT_LO:    rd_byte_lane = mlo;
        `WKT_OFF_EXP_STATE:  rd_byte_lane = exs;
        `WKT_OFF_DUTY_DUR:   rd_byte_lane = dur;
        `WKT_OFF_CONTROL:    rd_byte_lane = ctl;
        `WKT_OFF_STATUS:     rd_byte_lane = sts;
        `WKT_OFF_IRQ_STATUS: rd_byte_lane = irq;
        `WKT_OFF_RC_TRIM:    rd_byte_lane = trm;
        default:             rd_byte_lane = 8'h00;
      endcase
    end
  endfunction

  function addr_mapped;
    input [11:0] a;
    begin
      addr_mapped = (a[1:0] == 2'h0) && (a <= `WKT_OFF_RC_TRIM);
    end
  endfunction

  // registers
  reg [7:0]  config_ff;
  reg [7:0]  mant_hi_ff;
  reg [7:0]  mant_lo_ff;
  reg [7:0]  exp_state_ff;
  reg [7:0]  duty_dur_ff;
  reg [7:0]  control_ff;
  reg [1:0]  irq_status_ff;

  // synchronisers: first stage read only by the second
  reg [6:0]  sync1_ff;
  reg [6:0]  sync2_ff;
  reg        slow_d_ff;
  reg        rc_d_ff;

  reg [5:0]  state_ff;
  reg [33:0] pre_ff;
  reg [15:0] wake_cnt_ff;
  reg [7:0]  duty_cnt_ff;
  reg        rx_ext_ff;
  reg        rx_second_ff;
  reg [22:0] caliv_cnt_ff;
  reg [4:0]  cal_ticks_ff;
  reg [12:0] cal_cnt_ff;
  reg        cal_meas_ff;

  wire       apb_take  = psel & penable & pready_ff;
  wire       apb_wr    = apb_take & pwrite & addr_mapped(paddr);
  wire       apb_rd    = apb_take & ~pwrite;

  wire       rc_s      = sync2_ff[0];
  wire       xt_s      = sync2_ff[1];
  wire       pre_s     = sync2_ff[2];
  wire       rxerr_s   = sync2_ff[3];
  wire       pkt_s     = sync2_ff[4];
  wire       txd_s     = sync2_ff[5];
  wire       xor_s     = sync2_ff[6];

  wire       slow_s    = control_ff[`WKT_CTL_CLK_SEL] ? xt_s : rc_s;
  wire       slow_tick = slow_s & ~slow_d_ff;
  // calibration always times the rc source, whatever clocks the counter
  wire       rc_tick   = rc_s & ~rc_d_ff;

  wire [15:0] mantissa = {mant_hi_ff, mant_lo_ff};
  wire [4:0]  exponent = exp_state_ff[`WKT_EXP_HI:`WKT_EXP_LO];
  wire        sleep_sel = exp_state_ff[`WKT_EXP_SLEEP_SEL];
  wire [1:0]  duty_mode = config_ff[`WKT_CFG_MODE_HI:`WKT_CFG_MODE_LO];
  wire [2:0]  cal_iv    = config_ff[`WKT_CFG_CALIV_HI:`WKT_CFG_CALIV_LO];
  wire        timer_en  = config_ff[`WKT_CFG_EN];

  wire [33:0] unit_n    = unit_len(exponent);
  wire        unit_tick = slow_tick && (pre_ff == unit_n - 34'h1);

  // counting runs whenever the timer is on and the chip is neither off nor calibrating
  wire        counting  = timer_en & ~state_ff[0] & ~state_ff[3];
  wire        wake_evt  = counting & unit_tick & (mantissa != 16'h0) &
                          (wake_cnt_ff == mantissa - 16'h1);
  wire        duty_end  = unit_tick & (duty_cnt_ff == duty_dur_ff - 8'h1);

  wire [5:0]  idle_st   = sleep_sel ? ST_SLEEP : ST_READY;

  wire [22:0] caliv_len = CALIV_BASE << cal_iv;
  wire        caliv_due = config_ff[`WKT_CFG_CAL_EN] & slow_tick &
                          (caliv_cnt_ff == caliv_len - 23'h1);

  wire        ctl_wr    = apb_wr && (paddr == `WKT_OFF_CONTROL);
  wire        pwrup_cmd = ctl_wr & pwdata[`WKT_CTL_PWRUP_CMD];
  wire        shdn_cmd  = ctl_wr & pwdata[`WKT_CTL_SHDN_CMD];
  wire        sleep_cmd = ctl_wr & pwdata[`WKT_CTL_SLEEP_CMD];

  reg  [5:0]  nxt_state;
  reg         tx_done_evt;

  always @* begin
    nxt_state   = state_ff;
    tx_done_evt = 1'b0;
    case (state_ff)
      ST_OFF: begin
        if (pwrup_cmd) begin
          nxt_state = ST_CAL;
        end
      end
      ST_READY, ST_SLEEP: begin
        if (shdn_cmd) begin
          nxt_state = ST_OFF;
        end else if (pwrup_cmd || caliv_due) begin
          nxt_state = ST_CAL;
        end else if (wake_evt && duty_mode == `WKT_MODE_RX) begin
          nxt_state = ST_RX;
        end else if (wake_evt && duty_mode == `WKT_MODE_TX) begin
          nxt_state = ST_TX;
        end else if (wake_evt) begin
          nxt_state = idle_st;
        end else if (sleep_cmd) begin
          nxt_state = ST_SLEEP;
        end
      end
      ST_CAL: begin
        if (shdn_cmd) begin
          nxt_state = ST_OFF;
        end else if (cal_meas_ff && rc_tick && cal_ticks_ff == CAL_TICKS - 5'h1) begin
          nxt_state = ST_READY;
        end
      end
      ST_RX: begin
        if (shdn_cmd) begin
          nxt_state = ST_OFF;
        end else if (pkt_s || rxerr_s) begin
          nxt_state = idle_st;
        end else if (duty_end && (!rx_ext_ff || rx_second_ff)) begin
          nxt_state = idle_st;
        end
      end
      ST_TX: begin
        if (shdn_cmd) begin
          nxt_state = ST_OFF;
        end else if (txd_s) begin
          nxt_state   = idle_st;
          tx_done_evt = 1'b1;
        end
      end
      default: nxt_state = ST_OFF;
    endcase
  end

  wire [7:0] status_v = {1'b0, cal_meas_ff, state_ff};
  wire [7:0] nxt_rd   = rd_byte_lane(paddr, config_ff, mant_hi_ff, mant_lo_ff,
                                     exp_state_ff, duty_dur_ff, control_ff, status_v,
                                     {6'h00, irq_status_ff}, {1'b0, rc_trim_ff});
  wire       wake_ie  = control_ff[`WKT_CTL_WAKE_IE];
  wire       txd_ie   = control_ff[`WKT_CTL_TXDONE_IE];
  wire       irq_clr  = apb_wr && (paddr == `WKT_OFF_IRQ_STATUS);

  // set wins over a write-one clear in the same cycle
  wire [1:0] nxt_irq  = (irq_status_ff & ~({2{irq_clr}} & pwdata[1:0])) |
                        {tx_done_evt, wake_evt};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff              <= 32'h00000000;
      pready_ff              <= 1'b0;
      pslverr_ff             <= 1'b0;
      config_ff              <= `WKT_RST_CONFIG;
      mant_hi_ff             <= `WKT_RST_MANT_HI;
      mant_lo_ff             <= `WKT_RST_MANT_LO;
      exp_state_ff           <= `WKT_RST_EXP_STATE;
      duty_dur_ff            <= `WKT_RST_DUTY_DUR;
      control_ff             <= `WKT_RST_CONTROL;
      irq_status_ff          <= 2'h0;
      sync1_ff               <= 7'h00;
      sync2_ff               <= 7'h00;
      slow_d_ff              <= 1'b0;
      rc_d_ff                <= 1'b0;
      state_ff               <= ST_OFF;
      pre_ff                 <= 34'h000000000;
      wake_cnt_ff            <= 16'h0000;
      duty_cnt_ff            <= 8'h00;
      rx_ext_ff              <= 1'b0;
      rx_second_ff           <= 1'b0;
      caliv_cnt_ff           <= 23'h000000;
      cal_ticks_ff           <= 5'h00;
      cal_cnt_ff             <= 13'h0000;
      cal_meas_ff            <= 1'b0;
      interrupt_request_n_ff <= 1'b1;
      rx_enable_ff           <= 1'b0;
      tx_start_ff            <= 1'b0;
      battery_measure_ff     <= 1'b0;
      xo_enable_ff           <= 1'b0;
      rc_trim_ff             <= `WKT_RST_RC_TRIM;
      chip_state_ff          <= ST_OFF;
    end else if (ce) begin
      // apb: one wait state, answer always in the second access cycle
      pready_ff  <= psel & penable & ~pready_ff;
      pslverr_ff <= psel & penable & ~pready_ff & ~addr_mapped(paddr);
      if (psel & penable & ~pready_ff & ~pwrite) begin
        prdata_ff <= {24'h000000, nxt_rd};
      end else if (apb_rd) begin
        prdata_ff <= 32'h00000000;
      end
      if (apb_wr) begin
        case (paddr)
          `WKT_OFF_CONFIG:    config_ff    <= pwdata[7:0];
          `WKT_OFF_MANT_HI:   mant_hi_ff   <= pwdata[7:0];
          `WKT_OFF_MANT_LO:   mant_lo_ff   <= pwdata[7:0];
          `WKT_OFF_EXP_STATE: exp_state_ff <= {1'b0, pwdata[6], 1'b0, pwdata[4:0]};
          `WKT_OFF_DUTY_DUR:  duty_dur_ff  <= pwdata[7:0];
          // command bits are pulses and never stay set
          `WKT_OFF_CONTROL:   control_ff   <= {5'h00, pwdata[2:0]};
          default: ;
        endcase
      end
      irq_status_ff          <= nxt_irq;
      interrupt_request_n_ff <= ~((nxt_irq[0] & wake_ie) | (nxt_irq[1] & txd_ie));

      sync1_ff  <= {xo_ready, tx_done, packet_received, rx_error, preamble_detect,
                    xtal_clk_32k, rc_clk_32k};
      sync2_ff  <= sync1_ff;
      slow_d_ff <= slow_s;
      rc_d_ff   <= rc_s;

      // prescaler and wake counter, restart from zero on expiry
      if (!counting) begin
        pre_ff      <= 34'h000000000;
        wake_cnt_ff <= 16'h0000;
      end else if (slow_tick) begin
        pre_ff <= unit_tick ? 34'h000000000 : pre_ff + 34'h1;
        if (wake_evt) begin
          wake_cnt_ff <= 16'h0000;
        end else if (unit_tick) begin
          wake_cnt_ff <= (wake_cnt_ff >= mantissa - 16'h1) ? 16'h0000 : wake_cnt_ff + 16'h1;
        end
      end

      state_ff      <= nxt_state;
      chip_state_ff <= nxt_state;

      // rx active window counted in the same units as the wake period
      if (nxt_state == ST_RX && state_ff != ST_RX) begin
        duty_cnt_ff  <= 8'h00;
        rx_ext_ff    <= 1'b0;
        rx_second_ff <= 1'b0;
      end else if (state_ff == ST_RX) begin
        if (pre_s) begin
          rx_ext_ff <= 1'b1;
        end
        if (duty_end) begin
          duty_cnt_ff  <= 8'h00;
          rx_second_ff <= 1'b1;
        end else if (unit_tick) begin
          duty_cnt_ff <= duty_cnt_ff + 8'h01;
        end
      end
      rx_enable_ff       <= (nxt_state == ST_RX);
      tx_start_ff        <= (nxt_state == ST_TX) && (state_ff != ST_TX);
      battery_measure_ff <= wake_evt & config_ff[`WKT_CFG_BATT];

      // recalibration interval in slow ticks: 1 s << interval
      if (!config_ff[`WKT_CFG_CAL_EN] || state_ff == ST_CAL || state_ff == ST_OFF) begin
        caliv_cnt_ff <= 23'h000000;
      end else if (slow_tick) begin
        caliv_cnt_ff <= caliv_due ? 23'h000000 : caliv_cnt_ff + 23'h000001;
      end

      // calibration: crystal on, count pclk over fixed rc ticks, trim by one step
      xo_enable_ff <= (nxt_state == ST_CAL);
      if (state_ff != ST_CAL) begin
        cal_meas_ff  <= 1'b0;
        cal_ticks_ff <= 5'h00;
        cal_cnt_ff   <= 13'h0000;
      end else if (!cal_meas_ff) begin
        // wait for crystal, then align to an rc edge
        if (xor_s && rc_tick) begin
          cal_meas_ff <= 1'b1;
        end
      end else begin
        cal_cnt_ff <= (cal_cnt_ff == 13'h1FFF) ? cal_cnt_ff : cal_cnt_ff + 13'h0001;
        if (rc_tick) begin
          cal_ticks_ff <= cal_ticks_ff + 5'h01;
          if (cal_ticks_ff == CAL_TICKS - 5'h1) begin
            if (cal_cnt_ff > CAL_EXPECT && rc_trim_ff != 7'h7F) begin
              rc_trim_ff <= rc_trim_ff + 7'h01;
            end else if (cal_cnt_ff < CAL_EXPECT && rc_trim_ff != 7'h00) begin
              rc_trim_ff <= rc_trim_ff - 7'h01;
            end
          end
        end
      end
    end
  end

endmodule

// [bench/wkt_radio_model.sv]
// far-side model: slow clocks, crystal start-up and radio replies
`timescale 1ns/1ps
module wkt_radio_model #(
  parameter int RC_HALF = 15000,
  parameter int XT_HALF = 15259
) (
  input  logic       pclk,
  input  logic       xo_enable_ff,
  input  logic       tx_start_ff,
  input  logic       rx_enable_ff,
  input  logic [1:0] rx_mode,
  input  logic [7:0] tx_dly,
  output logic       rc_clk_32k,
  output logic       xtal_clk_32k,
  output logic       xo_ready,
  output logic       tx_done,
  output logic       preamble_detect,
  output logic       packet_received,
  output logic       rx_error
);
  logic [7:0] xo_cnt = 8'h00;
  logic [7:0] tx_cnt = 8'h00;
  logic [7:0] rx_cnt = 8'h00;
  initial begin
    rc_clk_32k = 1'b0;
    forever #RC_HALF rc_clk_32k = ~rc_clk_32k;
  end
  // crystal offset in phase so the two slow sources never line up
  initial begin
    xtal_clk_32k = 1'b0;
    #7001;
    forever #XT_HALF xtal_clk_32k = ~xtal_clk_32k;
  end
  // crystal takes a while to start, so calibration must wait for it
  always @(posedge pclk) xo_cnt <= !xo_enable_ff ? 8'h00 : xo_cnt + 8'(xo_cnt != 8'h40);
  assign xo_ready = xo_cnt == 8'h40;
  always @(posedge pclk) tx_cnt <= tx_start_ff ? tx_dly + 8'h05 : tx_cnt - 8'(tx_cnt != 8'h00);
  assign tx_done = tx_cnt != 8'h00 && tx_cnt < 8'h05;
  always @(posedge pclk) rx_cnt <= !rx_enable_ff ? 8'h00 : rx_cnt + 8'(rx_cnt != 8'hFF);
  // mode 0 silence, 1 preamble only, 2 full packet, 3 receive error
  assign preamble_detect = rx_enable_ff && rx_mode == 2'h1 && rx_cnt >= 8'h64;
  assign packet_received = rx_enable_ff && rx_mode == 2'h2 && rx_cnt >= 8'h64;
  assign rx_error = rx_enable_ff && rx_mode == 2'h3 && rx_cnt >= 8'h64;
endmodule

// [bench/wkt_asserts.sv]
// concurrent checks on the wake-up timer top ports
`timescale 1ns/1ps
module wkt_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire        pready_ff,
  input wire        pslverr_ff,
  input wire        tx_done,
  input wire        packet_received,
  input wire        rx_error,
  input wire        preamble_detect,
  input wire        tx_start_ff,
  input wire        rx_enable_ff,
  input wire        battery_measure_ff,
  input wire        xo_enable_ff,
  input wire [6:0]  rc_trim_ff,
  input wire [5:0]  chip_state_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_wait_a: assert property (psel && penable && !pready_ff |=> pready_ff)
    else $error("access not answered after one wait state");
  apb_error_a: assert property (psel && penable && !pready_ff &&
    (paddr > 12'h020 || paddr[1:0] != 2'b00) |=> pready_ff && pslverr_ff)
    else $error("bad address not refused");
  tx_pulse_a: assert property (tx_start_ff |=> !tx_start_ff)
    else $error("transmit start longer than one cycle");
  tx_state_a: assert property ($rose(tx_start_ff) |-> ##[0:1] chip_state_ff == 6'h20)
    else $error("transmit start outside transmit state");
  rx_state_a: assert property ($rose(rx_enable_ff) |-> ##[0:1] chip_state_ff == 6'h10)
    else $error("receive window outside receive state");
  state_onehot_a: assert property ($onehot(chip_state_ff))
    else $error("state not one-hot");
  tx_return_a: assert property (tx_done && chip_state_ff == 6'h20 |-> ##[1:8] chip_state_ff != 6'h20)
    else $error("no return to idle after transmit");
  rx_abort_a: assert property ((packet_received || rx_error) && rx_enable_ff |-> ##[1:8] !rx_enable_ff)
    else $error("receive window kept after packet end or error");
  cal_xo_a: assert property ($rose(chip_state_ff[3]) |-> ##[0:1] xo_enable_ff)
    else $error("crystal not started for calibration");
  trim_step_a: assert property ($changed(rc_trim_ff) |-> $past(chip_state_ff) == 6'h08 &&
    (rc_trim_ff == $past(rc_trim_ff) + 7'h01 || rc_trim_ff == $past(rc_trim_ff) - 7'h01))
    else $error("trim moved outside calibration or by more than one");
  batt_pulse_a: assert property (battery_measure_ff |=> !battery_measure_ff)
    else $error("battery pulse longer than one cycle");
  cover property ($rose(tx_start_ff));
  cover property (rx_enable_ff && preamble_detect);
  cover property ($changed(rc_trim_ff));
endmodule
bind wkt_top wkt_asserts wkt_asserts_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready_ff(pready_ff),
  .pslverr_ff(pslverr_ff), .tx_done(tx_done), .packet_received(packet_received), .rx_error(rx_error),
  .preamble_detect(preamble_detect), .tx_start_ff(tx_start_ff), .rx_enable_ff(rx_enable_ff),
  .battery_measure_ff(battery_measure_ff), .xo_enable_ff(xo_enable_ff), .rc_trim_ff(rc_trim_ff),
  .chip_state_ff(chip_state_ff));

// [bench/wkt_top_tb.sv]
// self-checking bench: registers, calibration, wake, transmit and receive polling
`timescale 1ns/1ps
`include "wkt_defs.vh"
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin n_errors++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, x); end end
`define WAITC(c, n) for (int k = 0; !(c); k++) begin if (k == (n)) begin n_errors++; conclude(); end \
  @(posedge pclk); end
module wkt_top_tb;
  localparam int RC_HALF = 15000;
  localparam int XT_HALF = 15259;
  localparam int RC_CYC = 2 * RC_HALF / 100;
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata_ff, q;
  logic        pready_ff, pslverr_ff, err, rc_clk_32k, xtal_clk_32k, preamble_detect, rx_error;
  logic        packet_received, tx_done, xo_ready, interrupt_request_n_ff, rx_enable_ff, tx_start_ff;
  logic        battery_measure_ff, xo_enable_ff;
  logic [6:0]  rc_trim_ff;
  logic [5:0]  chip_state_ff;
  logic [1:0]  rx_mode = 2'h0;
  logic [7:0]  tx_dly = 8'h10;
  logic [11:0] offs [6] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014};
  logic [31:0] msk [6] = '{32'hFF, 32'hFF, 32'hFF, 32'h5F, 32'hFF, 32'h07};
  int          n_errors = 0, checks_done = 0, n_batt = 0;
  wkt_top wkt_top_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .rc_clk_32k(rc_clk_32k), .xtal_clk_32k(xtal_clk_32k), .preamble_detect(preamble_detect),
    .rx_error(rx_error), .packet_received(packet_received), .tx_done(tx_done), .xo_ready(xo_ready),
    .interrupt_request_n_ff(interrupt_request_n_ff), .rx_enable_ff(rx_enable_ff), .tx_start_ff(tx_start_ff),
    .battery_measure_ff(battery_measure_ff), .xo_enable_ff(xo_enable_ff), .rc_trim_ff(rc_trim_ff),
    .chip_state_ff(chip_state_ff));
  wkt_radio_model #(.RC_HALF(RC_HALF), .XT_HALF(XT_HALF)) wkt_radio_model_i (
    .pclk(pclk), .xo_enable_ff(xo_enable_ff), .tx_start_ff(tx_start_ff), .rx_enable_ff(rx_enable_ff),
    .rx_mode(rx_mode), .tx_dly(tx_dly), .rc_clk_32k(rc_clk_32k), .xtal_clk_32k(xtal_clk_32k),
    .xo_ready(xo_ready), .tx_done(tx_done), .preamble_detect(preamble_detect),
    .packet_received(packet_received), .rx_error(rx_error));
  initial begin
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) n_batt <= n_batt + int'(battery_measure_ff);
  function automatic logic [6:0] trim_after(int cnt, logic [6:0] t);
    return cnt > `WKT_CAL_EXPECT ? t + 7'h01 : cnt < `WKT_CAL_EXPECT ? t - 7'h01 : t;
  endfunction
  // receive window: one unit silent, two with preamble, short on packet end or error
  function automatic int rx_cyc(int m);
    return m == 0 ? 4 * RC_CYC : m == 1 ? 8 * RC_CYC : 105;
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one idle cycle after each transfer keeps psel from being driven twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge pclk);
      if (pready_ff === 1'b1) break;
    end
    if (k == 64) begin
      n_errors++;
      conclude();
    end
    q = prdata_ff;
    err = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(q, x)
  endtask
  initial begin
    logic [31:0] v;
    longint t0, t1;
    void'($urandom(43));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(chip_state_ff, 6'h01)
    `CHK(interrupt_request_n_ff, 1'b1)
    for (int i = 0; i < 6; i++) begin
      rd(offs[i], 32'h0);
      v = $urandom & msk[i];
      wr(offs[i], v);
      rd(offs[i], v);
      wr(offs[i], 32'h0);
    end
    rd(12'h024, 32'h0);
    `CHK(err, 1'b1)
    wr(12'h002, 32'hFF);
    `CHK(err, 1'b1)
    rd(`WKT_OFF_STATUS, 32'h01);
    rd(`WKT_OFF_RC_TRIM, 32'h40);
    wr(`WKT_OFF_CONTROL, 32'h10);
    `WAITC(chip_state_ff === 6'h08, 10)
    @(posedge pclk);
    `CHK(xo_enable_ff, 1'b1)
    `WAITC(chip_state_ff === 6'h02, 20000)
    `CHK(rc_trim_ff, trim_after(16 * RC_CYC, 7'h40))
    wr(`WKT_OFF_MANT_LO, 32'h03);
    wr(`WKT_OFF_EXP_STATE, 32'h41);
    wr(`WKT_OFF_CONTROL, 32'h02);
    wr(`WKT_OFF_CONFIG, 32'h03);
    `WAITC(interrupt_request_n_ff === 1'b0, 20000)
    t0 = $time;
    @(posedge pclk);
    `CHK(chip_state_ff, 6'h04)
    `CHK(n_batt, 1)
    rd(`WKT_OFF_IRQ_STATUS, 32'h01);
    wr(`WKT_OFF_IRQ_STATUS, 32'h01);
    repeat (2) @(posedge pclk);
    `CHK(interrupt_request_n_ff, 1'b1)
    `WAITC(interrupt_request_n_ff === 1'b0, 20000)
    t1 = $time;
    `CHK((t1 - t0) / 100, longint'(3 * 4 * 2 * RC_CYC))
    wr(`WKT_OFF_IRQ_STATUS, 32'h01);
    // crystal drives the counter: one full period, wake to wake, within a pclk
    wr(`WKT_OFF_CONTROL, 32'h01);
    v = n_batt;
    `WAITC(n_batt != v, 9000)
    t0 = $time;
    v = n_batt;
    `WAITC(n_batt != v, 9000)
    t1 = $time;
    `CHK(t1 - t0 > 24 * 2 * XT_HALF - 100 && t1 - t0 < 24 * 2 * XT_HALF + 100, 1'b1)
    repeat (2) @(posedge pclk);
    `CHK(interrupt_request_n_ff, 1'b1)
    rd(`WKT_OFF_IRQ_STATUS, 32'h01);
    wr(`WKT_OFF_CONFIG, 32'h00);
    wr(`WKT_OFF_IRQ_STATUS, 32'h03);
    wr(`WKT_OFF_MANT_LO, 32'h04);
    wr(`WKT_OFF_EXP_STATE, 32'h00);
    wr(`WKT_OFF_CONTROL, 32'h04);
    tx_dly <= 8'($urandom_range(60, 5));
    wr(`WKT_OFF_CONFIG, 32'h09);
    `WAITC(tx_start_ff === 1'b1, 8000)
    @(posedge pclk);
    `CHK(chip_state_ff, 6'h20)
    `WAITC(chip_state_ff === 6'h02, 200)
    repeat (2) @(posedge pclk);
    `CHK(interrupt_request_n_ff, 1'b0)
    rd(`WKT_OFF_IRQ_STATUS, 32'h03);
    wr(`WKT_OFF_CONFIG, 32'h00);
    wr(`WKT_OFF_IRQ_STATUS, 32'h03);
    wr(`WKT_OFF_DUTY_DUR, 32'h01);
    wr(`WKT_OFF_CONFIG, 32'h05);
    for (int m = 0; m < 4; m++) begin
      rx_mode <= 2'(m);
      `WAITC(rx_enable_ff === 1'b1, 8000)
      t0 = $time;
      `WAITC(rx_enable_ff === 1'b0, 4000)
      t1 = $time;
      `CHK((t1 - t0) / 100 + 8 >= rx_cyc(m) && (t1 - t0) / 100 <= rx_cyc(m) + 8, 1'b1)
      @(posedge pclk);
      `CHK(chip_state_ff, 6'h02)
    end
    wr(`WKT_OFF_CONFIG, 32'h00);
    wr(`WKT_OFF_CONTROL, 32'h20);
    `WAITC(chip_state_ff === 6'h01, 10)
    wr(`WKT_OFF_CONTROL, 32'h10);
    `WAITC(chip_state_ff === 6'h02, 20000)
    `CHK(rc_trim_ff, trim_after(16 * RC_CYC, 7'h3F))
    conclude();
  end
endmodule
